//--- src/io_space_defines.svh
// Offsets, field positions and reset values for the I/O space decoder.
// Assumes an 8-bit data path and an 8-bit data-space address from the core.
`ifndef IO_SPACE_DEFINES_SVH
`define IO_SPACE_DEFINES_SVH

`define IO_LOW_LAST        6'h1f
`define IO_PORT_LAST       6'h3f
`define IO_DATA_OFFSET     8'h20
`define IO_EXT_FIRST       8'h60
`define IO_EXT_LAST        8'hff
`define GS_ZERO_ADDR       5'h1c
`define GS_ONE_ADDR        5'h1d
`define GS_TWO_ADDR        5'h1e
`define GS_THREE_ADDR      5'h1f
`define GS_RESET           8'h00
`define STAT_ADDR          5'h1b
`define STAT_RESET         8'h00
`define STAT_W1C_MASK      8'hff
`define NUM_STORE          4

`endif

//--- src/io_space_gp_register_bank.sv
// I/O space decoder with four general storage registers and a status byte.
// Assumes one request per cycle from the core, synchronous to I_CLK.
`timescale 1ns/1ps
module io_space_gp_register_bank
	import io_space_pkg::*;
(
	input  wire logic   I_CLK,
	input  wire logic   I_RESET,
	input  wire logic   I_CE,
	input  wire io_op_e i_op,
	input  wire logic   [7:0] i_addr,
	input  wire logic   [2:0] i_bit,
	input  wire byte_t  i_wdata,
	input  wire byte_t  i_stat_set,
	input  wire byte_t  i_ext_rdata,
	output byte_t       o_rdata,
	output logic        o_rvalid,
	output logic        o_bit,
	output logic        o_ext_rd,
	output logic        o_ext_wr,
	output logic        [7:0] o_ext_addr,
	output byte_t       o_ext_wdata,
	output logic        o_bad_access,
	output byte_t       o_store0,
	output byte_t       o_store1,
	output byte_t       o_store2,
	output byte_t       o_store3
);
`include "io_space_defines.svh"

	// ***************************************************************
	// Address decode
	// ***************************************************************
	wire        is_port_op;
	wire        is_bit_op;
	wire        is_mem_op;
	wire        port_ok;
	wire        bit_ok;
	wire        mem_io;
	wire        mem_ext;
	wire [5:0]  io_addr;
	wire        io_valid;
	wire        do_read;
	wire        do_write;
	wire        do_bset;
	wire        do_bclr;

	assign is_port_op = (i_op == OP_IN) || (i_op == OP_OUT);
	assign is_bit_op  = (i_op == OP_SBI) || (i_op == OP_CBI);
	assign is_mem_op  = (i_op == OP_LOAD) || (i_op == OP_STORE);
	assign port_ok    = (i_addr[7:6] == 2'b00) && (i_addr[5:0] <= `IO_PORT_LAST);
	assign bit_ok     = (i_addr[7:6] == 2'b00) && (i_addr[5:0] <= `IO_LOW_LAST);
	// Data space 0x20..0x5f maps back onto I/O 0x00..0x3f
	assign mem_io     = (i_addr >= `IO_DATA_OFFSET) && (i_addr < `IO_EXT_FIRST);
	assign mem_ext    = (i_addr >= `IO_EXT_FIRST) && (i_addr <= `IO_EXT_LAST);
	assign io_addr    = is_mem_op ? 6'(i_addr - `IO_DATA_OFFSET) : i_addr[5:0];
	assign io_valid   = (is_port_op && port_ok) || (is_mem_op && mem_io) || (is_bit_op && bit_ok);
	assign do_read    = io_valid && ((i_op == OP_IN) || (i_op == OP_LOAD));
	assign do_write   = io_valid && ((i_op == OP_OUT) || (i_op == OP_STORE));
	assign do_bset    = io_valid && (i_op == OP_SBI);
	assign do_bclr    = io_valid && (i_op == OP_CBI);

	// ***************************************************************
	// Storage registers
	// ***************************************************************
	wire [4:0] store_addr [`NUM_STORE];
	byte_t     store_val  [`NUM_STORE];

	assign store_addr[0] = `GS_ZERO_ADDR;
	assign store_addr[1] = `GS_ONE_ADDR;
	assign store_addr[2] = `GS_TWO_ADDR;
	assign store_addr[3] = `GS_THREE_ADDR;

	genvar g;
	generate
		for (g = 0; g < `NUM_STORE; g++) begin : g_store
			wire hit;
			assign hit = (io_addr == {1'b0, store_addr[g]});
			// No side effects beyond holding the byte
			io_store_reg u_store (
				.i_clk   (I_CLK),
				.i_reset (I_RESET),
				.i_ce    (I_CE),
				.i_wr    (do_write && hit),
				.i_bset  (do_bset && hit),
				.i_bclr  (do_bclr && hit),
				.i_bit   (i_bit),
				.i_wdata (i_wdata),
				.o_value (store_val[g])
			);
		end
	endgenerate

	// ***************************************************************
	// Status flags, write one to clear
	// ***************************************************************
	byte_t stat_q;
	byte_t stat_d;
	byte_t stat_clr;
	byte_t bit_mask;
	wire   stat_hit;

	assign stat_hit = (io_addr == {1'b0, `STAT_ADDR});
	assign bit_mask = 8'h01 << i_bit;
	// Byte write clears flags under ones; SBI clears only the named bit, CBI clears nothing
	assign stat_clr = !stat_hit ? 8'h00 :
	                  do_write  ? (i_wdata & `STAT_W1C_MASK) :
	                  do_bset   ? (bit_mask & `STAT_W1C_MASK) : 8'h00;
	// Set wins over clear so a same-cycle event is kept
	assign stat_d   = (stat_q & ~stat_clr) | i_stat_set;

	// ***************************************************************
	// Read mux
	// ***************************************************************
	byte_t io_rdata;

	assign io_rdata = (io_addr == {1'b0, `GS_ZERO_ADDR})  ? store_val[0] :
	                  (io_addr == {1'b0, `GS_ONE_ADDR})   ? store_val[1] :
	                  (io_addr == {1'b0, `GS_TWO_ADDR})   ? store_val[2] :
	                  (io_addr == {1'b0, `GS_THREE_ADDR}) ? store_val[3] :
	                  stat_hit ? stat_q : 8'h00;

	wire ext_rd;
	wire ext_wr;
	wire bad;

	assign ext_rd = (i_op == OP_LOAD) && mem_ext;
	assign ext_wr = (i_op == OP_STORE) && mem_ext;
	// Flag refused accesses; the op is dropped, not aliased
	assign bad    = (i_op != OP_NONE) && !io_valid && !ext_rd && !ext_wr;

	// ***************************************************************
	// Registers and outputs
	// ***************************************************************
	logic ext_pend_q;

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			stat_q       <= `STAT_RESET;
			o_rdata      <= 8'h00;
			o_rvalid     <= 1'b0;
			o_bit        <= 1'b0;
			o_ext_rd     <= 1'b0;
			o_ext_wr     <= 1'b0;
			o_ext_addr   <= 8'h00;
			o_ext_wdata  <= 8'h00;
			o_bad_access <= 1'b0;
			ext_pend_q   <= 1'b0;
		end else if (I_CE) begin
			stat_q       <= stat_d;
			o_rvalid     <= do_read;
			o_rdata      <= do_read ? io_rdata : 8'h00;
			o_bit        <= (is_bit_op && bit_ok) ? io_rdata[i_bit] : 1'b0;
			o_ext_rd     <= ext_rd;
			o_ext_wr     <= ext_wr;
			o_ext_addr   <= (ext_rd || ext_wr) ? i_addr : 8'h00;
			o_ext_wdata  <= ext_wr ? i_wdata : 8'h00;
			o_bad_access <= bad;
			ext_pend_q   <= ext_rd;
		end
	end

	// Extended read data are sampled while o_ext_rd is high into ext_rdata_q, which holds them one cycle then clears, and feeds no output
	byte_t ext_rdata_q;

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			ext_rdata_q <= 8'h00;
		end else if (I_CE) begin
			ext_rdata_q <= ext_pend_q ? i_ext_rdata : 8'h00;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			o_store0 <= `GS_RESET;
			o_store1 <= `GS_RESET;
			o_store2 <= `GS_RESET;
			o_store3 <= `GS_RESET;
		end else if (I_CE) begin
			o_store0 <= store_val[0];
			o_store1 <= store_val[1];
			o_store2 <= store_val[2];
			o_store3 <= store_val[3];
		end
	end

	logic unused_ext;
	assign unused_ext = ^ext_rdata_q;

endmodule // io_space_gp_register_bank

//--- src/io_space_pkg.sv
// Types shared by the I/O space decoder files.
// Assumes io_space_defines.svh is available for the constants.
package io_space_pkg;

	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_IN    = 3'h1,
		OP_OUT   = 3'h3,
		OP_SBI   = 3'h2,
		OP_CBI   = 3'h6,
		OP_LOAD  = 3'h7,
		OP_STORE = 3'h5
	} io_op_e;

	typedef logic [7:0] byte_t;

endpackage

//--- src/io_store_reg.sv
// One 8-bit storage register with byte write and single-bit set/clear.
// Assumes the caller has decoded the address and at most one strobe is high.
`timescale 1ns/1ps
module io_store_reg
	import io_space_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_reset,
	input  wire logic  i_ce,
	input  wire logic  i_wr,
	input  wire logic  i_bset,
	input  wire logic  i_bclr,
	input  wire logic  [2:0] i_bit,
	input  wire byte_t i_wdata,
	output byte_t      o_value
);
`include "io_space_defines.svh"

	byte_t value_q;
	byte_t value_d;
	byte_t bit_mask;

	assign bit_mask = 8'h01 << i_bit;
	// Bit ops touch only the addressed bit
	assign value_d = i_wr   ? i_wdata :
	                 i_bset ? (value_q | bit_mask) :
	                 i_bclr ? (value_q & ~bit_mask) : value_q;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			value_q <= `GS_RESET;
		end else if (i_ce) begin
			value_q <= value_d;
		end
	end

	assign o_value = value_q;

endmodule // io_store_reg

//--- tb/cpu_core_model.sv
// Core model issuing one I/O or load/store request at a time.
// Assumes requests change at the falling edge of the clock.
`timescale 1ns/1ps
module cpu_core_model
	import io_space_pkg::*;
(
	input  wire logic i_clk,
	output io_op_e    o_op,
	output logic      [7:0] o_addr,
	output logic      [2:0] o_bit,
	output byte_t     o_wdata
);
	// ****************************************
	// Requests
	// ****************************************
	initial begin
		o_op = OP_NONE;
		o_addr = 8'h00;
		o_bit = 3'h0;
		o_wdata = 8'h00;
	end
	// Callers keep reserved bits zero and avoid reserved addresses
	task automatic issue(input io_op_e op, input logic [7:0] a, input logic [2:0] b, input byte_t d);
		@(negedge i_clk);
		o_op = op;
		o_addr = a;
		o_bit = b;
		o_wdata = d;
		@(negedge i_clk);
		o_op = OP_NONE;
		// Released address and data lines flip so stale values never look valid
		o_addr = ~a;
		o_wdata = ~d;
	endtask
endmodule // cpu_core_model

//--- tb/io_space_checker.sv
// Port assertions for the I/O space decoder.
// Assumes a bind onto io_space_gp_register_bank, one clock domain.
`timescale 1ns/1ps
module io_space_checker
	import io_space_pkg::*;
(
	input wire logic   I_CLK,
	input wire logic   I_RESET,
	input wire logic   I_CE,
	input wire io_op_e i_op,
	input wire logic   [7:0] i_addr,
	input wire byte_t  i_wdata,
	input wire logic   o_rvalid,
	input wire logic   o_bad_access,
	input wire logic   o_ext_rd,
	input wire logic   o_ext_wr,
	input wire logic   [7:0] o_ext_addr,
	input wire byte_t  o_store0
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	port_read_a: assert property (I_CE && i_op == OP_IN && i_addr <= 8'h3f |=> o_rvalid)
		else $error("port read not answered");
	port_refuse_a: assert property (I_CE && i_op == OP_IN && i_addr > 8'h3f |=> o_bad_access && !o_rvalid)
		else $error("high port read not refused");
	bit_refuse_a: assert property (I_CE && i_op inside {OP_SBI, OP_CBI} && i_addr > 8'h1f |=> o_bad_access)
		else $error("bit op above low window taken");
	ext_load_a: assert property (I_CE && i_op == OP_LOAD && i_addr >= 8'h60 |=> o_ext_rd && o_ext_addr == $past(i_addr))
		else $error("extended load not forwarded");
	ext_store_a: assert property (I_CE && i_op == OP_STORE && i_addr >= 8'h60 |=> o_ext_wr && !o_ext_rd)
		else $error("extended store not forwarded");
	port_no_ext_a: assert property (I_CE && i_op inside {OP_IN, OP_OUT} |=> !o_ext_rd && !o_ext_wr)
		else $error("port op reached extended space");
	load_low_a: assert property (I_CE && i_op == OP_LOAD && i_addr < 8'h20 |=> o_bad_access)
		else $error("load below offset taken");
	store_copy_a: assert property (I_CE && i_op == OP_OUT && i_addr == 8'h1c |-> ##2 o_store0 == $past(i_wdata, 2))
		else $error("store zero lost write");
endmodule // io_space_checker

bind io_space_gp_register_bank io_space_checker chk_u (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_CE(I_CE), .i_op(i_op),
	.i_addr(i_addr), .i_wdata(i_wdata), .o_rvalid(o_rvalid), .o_bad_access(o_bad_access), .o_ext_rd(o_ext_rd),
	.o_ext_wr(o_ext_wr), .o_ext_addr(o_ext_addr), .o_store0(o_store0));

//--- tb/testbench.sv
// Self-checking bench for the I/O space decoder.
// Assumes the core model drives requests; extended read data tied low.
`timescale 1ns/1ps
module testbench;
	import io_space_pkg::*;
	// ****************************************
	// Harness
	// ****************************************
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       ce = 1'b1;
	byte_t      stat = 8'h00;
	io_op_e     op;
	logic [7:0] addr, ext_addr;
	logic [2:0] bitn;
	byte_t      wdata, rdata, ext_wdata;
	byte_t      st [4];
	logic       rvalid, tbit, ext_rd, ext_wr, bad;
	int         n_fail = 0;
	int         n_compared = 0;
	always #2.5 clk = ~clk;
	cpu_core_model core_u (.i_clk(clk), .o_op(op), .o_addr(addr), .o_bit(bitn), .o_wdata(wdata));
	io_space_gp_register_bank dut_u (.I_CLK(clk), .I_RESET(rst), .I_CE(ce), .i_op(op), .i_addr(addr), .i_bit(bitn),
		.i_wdata(wdata), .i_stat_set(stat), .i_ext_rdata(8'h00), .o_rdata(rdata), .o_rvalid(rvalid), .o_bit(tbit),
		.o_ext_rd(ext_rd), .o_ext_wr(ext_wr), .o_ext_addr(ext_addr), .o_ext_wdata(ext_wdata), .o_bad_access(bad),
		.o_store0(st[0]), .o_store1(st[1]), .o_store2(st[2]), .o_store3(st[3]));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input byte_t exp);
		core_u.issue(OP_IN, a, 3'h0, 8'h00);
		check({7'h0, rvalid}, 8'h01);
		check(rdata, exp);
	endtask
	task automatic refused(input io_op_e o, input logic [7:0] a);
		core_u.issue(o, a, 3'h0, 8'h00);
		check({5'h0, bad, ext_wr, ext_rd}, 8'h04);
	endtask
	task automatic give_verdict();
		$display("compared %0d, wrong %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		for (int n = 0; n < 4; n++) begin
			check(st[n], 8'h00);
			rd(8'(28 + n), 8'h00);
		end
	endtask
	task automatic t_rw();
		for (int n = 0; n < 4; n++) begin
			core_u.issue(OP_OUT, 8'(28 + n), 3'h0, 8'ha5 ^ 8'(n));
			@(negedge clk);
			check(st[n], 8'ha5 ^ 8'(n));
			core_u.issue(OP_LOAD, 8'(60 + n), 3'h0, 8'h00);
			check(rdata, 8'ha5 ^ 8'(n));
		end
		core_u.issue(OP_STORE, 8'h3d, 3'h0, 8'h3c);
		rd(8'h1d, 8'h3c);
	endtask
	task automatic t_bits();
		core_u.issue(OP_SBI, 8'h1c, 3'h1, 8'h00);
		check({7'h0, tbit}, 8'h00);
		rd(8'h1c, 8'ha7);
		core_u.issue(OP_SBI, 8'h1c, 3'h1, 8'h00);
		check({7'h0, tbit}, 8'h01);
		core_u.issue(OP_CBI, 8'h1c, 3'h7, 8'h00);
		rd(8'h1c, 8'h27);
		core_u.issue(OP_CBI, 8'h1c, 3'h3, 8'h00);
		check({7'h0, tbit}, 8'h00);
		core_u.issue(OP_SBI, 8'h1f, 3'h0, 8'h00);
		check({7'h0, tbit}, 8'h00);
		rd(8'h1f, 8'ha7);
	endtask
	// Clock enable low must freeze the storage byte
	task automatic t_freeze();
		@(negedge clk);
		ce = 1'b0;
		core_u.issue(OP_OUT, 8'h1c, 3'h0, 8'h11);
		ce = 1'b1;
		@(negedge clk);
		@(negedge clk);
		check(st[0], 8'h27);
	endtask
	task automatic t_stat();
		@(negedge clk);
		stat = 8'h81;
		@(negedge clk);
		stat = 8'h00;
		rd(8'h1b, 8'h81);
		core_u.issue(OP_SBI, 8'h1b, 3'h0, 8'h00);
		rd(8'h1b, 8'h80);
		core_u.issue(OP_OUT, 8'h1b, 3'h0, 8'h00);
		rd(8'h1b, 8'h80);
		core_u.issue(OP_OUT, 8'h1b, 3'h0, 8'h80);
		rd(8'h1b, 8'h00);
	endtask
	task automatic t_ext();
		core_u.issue(OP_STORE, 8'hff, 3'h0, 8'h5c);
		check({6'h0, ext_wr, ext_rd}, 8'h02);
		check(ext_addr, 8'hff);
		check(ext_wdata, 8'h5c);
		core_u.issue(OP_LOAD, 8'h60, 3'h0, 8'h00);
		check({6'h0, ext_wr, ext_rd}, 8'h01);
		refused(OP_IN, 8'h60);
		refused(OP_SBI, 8'h20);
		refused(OP_LOAD, 8'h10);
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_rw();
		t_bits();
		t_freeze();
		t_stat();
		t_ext();
		give_verdict();
	end
	// Whole run is under a hundred cycles
	initial begin
		#20000;
		n_fail++;
		give_verdict();
	end
endmodule // testbench
